/* verilog/fsc_capture.sv */
/*
  Host-side controller for a 6-bit flash converter: generates the strobe
  with adjustable high and low phases, drives the output-disable pin, and
  captures the data word and below-range flag on a selectable strobe edge.
  Assumes the converter's open-collector outputs are pulled up outside, and
  that control inputs come from logic on CLK.
*/
`include "fsc_cfg.svh"

// Contract
// - Strobe high phase lasts at least 20 ns.
// - Strobe low phase lasts at least 40 ns.
// - Strobe stays low until the new encoded word reaches the latch.
// - Sampling rate stays at or below 16 million samples per second.
// - Word N may be invalid until 120 ns after its falling edge.
// - Word N may go invalid 50 ns after the next falling edge.
// - Low time over 120 ns: take word N on rising edge N+1.
// - Up to 8.3 MHz, word N may be taken on falling edge N+1.
// - Low time under 50 ns: take word N-1 on rising edge N+1.
// - Above 14 MHz the capture instant is trimmed per device.
// - Strobe duty cycle is adjustable near the maximum rate.
module fsc_capture #(
  parameter int CNT_W = 8,
  parameter int TRIM_W = 4,
  parameter int TAG_W = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Control from user logic
  input wire logic RUN,
  input wire logic [CNT_W-1:0] HIGH_CYCLES,
  input wire logic [CNT_W-1:0] LOW_CYCLES,
  input wire logic [1:0] CAPTURE_MODE,
  input wire logic [TRIM_W-1:0] CAPTURE_TRIM,
  input wire logic OUTPUT_ON,
  // Converter pins
  output logic STROBE,
  output logic OUT_DISABLE,
  input wire logic [5:0] DATA_PIN,
  input wire logic UNDER_N_PIN,
  // Captured word to user logic
  output logic [5:0] WORD,
  output logic BELOW_RANGE,
  output logic FULL_SCALE,
  output logic [TAG_W-1:0] WORD_TAG,
  output logic WORD_VALID,
  output logic TIMING_FAULT,
  output logic BUSY
);

  // ==========================================================
  // Pin synchroniser for the data bits and the below-range flag
  logic [6:0] pins_lvl;

  fsc_pin_sync #(
    .WIDTH(7),
    .IDLE(7'h7F)
  ) fsc_pin_sync_inst (
    .clk(CLK),
    .reset(RESET),
    .pin_in({UNDER_N_PIN, DATA_PIN}),
    .level_out(pins_lvl)
  );

  // ==========================================================
  // Phase lengths, clamped to the converter's least figures
  logic [CNT_W-1:0] high_len, low_len;
  logic [CNT_W:0] period_len;

  always_comb begin
    high_len = HIGH_CYCLES;
    low_len = LOW_CYCLES;
    if (high_len < CNT_W'(`FSC_HIGH_MIN_CYC)) begin
      high_len = CNT_W'(`FSC_HIGH_MIN_CYC);
    end
    if (low_len < CNT_W'(`FSC_LOW_MIN_CYC)) begin
      low_len = CNT_W'(`FSC_LOW_MIN_CYC);
    end
    period_len = {1'b0, high_len} + {1'b0, low_len};
    if (period_len < (CNT_W + 1)'(`FSC_PERIOD_MIN_CYC)) begin
      high_len = high_len + CNT_W'(1);
    end
  end

  // ==========================================================
  // Strobe generator; idles high so the comparators keep tracking
  fsc_pkg::fsc_state_e state_reg, state_next;
  logic [CNT_W-1:0] phase_reg, phase_next;
  logic strobe_reg, strobe_next;
  logic fall_evt, rise_evt;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    strobe_next = strobe_reg;
    fall_evt = 1'b0;
    rise_evt = 1'b0;
    case (state_reg)
      fsc_pkg::FSC_IDLE: begin
        strobe_next = 1'b1;
        if (RUN) begin
          state_next = fsc_pkg::FSC_HIGH;
          phase_next = CNT_W'(1);
        end
      end
      fsc_pkg::FSC_HIGH: begin
        // Hold high long enough for the comparators to settle
        if (phase_reg >= high_len) begin
          state_next = fsc_pkg::FSC_LOW;
          phase_next = CNT_W'(1);
          strobe_next = 1'b0;
          fall_evt = 1'b1;
        end else begin
          phase_next = phase_reg + CNT_W'(1);
        end
      end
      fsc_pkg::FSC_LOW: begin
        // No early rise: the rising edge latches the encoded word
        if (phase_reg >= low_len) begin
          state_next = RUN ? fsc_pkg::FSC_HIGH : fsc_pkg::FSC_IDLE;
          phase_next = CNT_W'(1);
          strobe_next = 1'b1;
          rise_evt = 1'b1;
        end else begin
          phase_next = phase_reg + CNT_W'(1);
        end
      end
      default: begin
        state_next = fsc_pkg::FSC_IDLE;
        phase_next = '0;
        strobe_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= fsc_pkg::FSC_IDLE;
      phase_reg <= '0;
      strobe_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      strobe_reg <= strobe_next;
    end
  end

  // ==========================================================
  // Sample numbering and edge selection
  // Tag names the sample whose word is taken at the chosen edge.
  logic [TAG_W-1:0] samp_reg, samp_next;
  logic arm_evt;
  logic [TAG_W-1:0] arm_tag;

  always_comb begin
    samp_next = samp_reg;
    if (fall_evt) begin
      samp_next = samp_reg + TAG_W'(1);
    end
    arm_evt = 1'b0;
    arm_tag = samp_reg - TAG_W'(1);
    case (CAPTURE_MODE)
      `FSC_MODE_RISE_NEXT: begin
        arm_evt = rise_evt;
      end
      `FSC_MODE_FALL_NEXT: begin
        arm_evt = fall_evt;
      end
      `FSC_MODE_RISE_LAG: begin
        arm_evt = rise_evt;
        arm_tag = samp_reg - TAG_W'(2);
      end
      `FSC_MODE_TRIMMED: begin
        arm_evt = fall_evt;
      end
      default: begin
        arm_evt = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Capture trim: a later edge restarts a pending capture
  logic pend_reg, pend_next;
  logic [TRIM_W-1:0] trim_reg, trim_next;
  logic [TAG_W-1:0] ptag_reg, ptag_next;
  logic take;

  always_comb begin
    pend_next = pend_reg;
    trim_next = trim_reg;
    ptag_next = ptag_reg;
    take = 1'b0;
    if (arm_evt) begin
      if (CAPTURE_TRIM == '0) begin
        take = 1'b1;
        pend_next = 1'b0;
      end else begin
        pend_next = 1'b1;
        trim_next = CAPTURE_TRIM;
      end
      ptag_next = arm_tag;
    end else if (pend_reg) begin
      if (trim_reg == TRIM_W'(1)) begin
        take = 1'b1;
        pend_next = 1'b0;
      end
      trim_next = trim_reg - TRIM_W'(1);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      samp_reg <= '0;
      pend_reg <= 1'b0;
      trim_reg <= '0;
      ptag_reg <= '0;
    end else begin
      samp_reg <= samp_next;
      pend_reg <= pend_next;
      trim_reg <= trim_next;
      ptag_reg <= ptag_next;
    end
  end

  // ==========================================================
  // Capture register; data and flag always from the same edge
  logic [5:0] word_reg, word_next;
  logic below_reg, below_next;
  logic full_reg, full_next;
  logic [TAG_W-1:0] tag_reg, tag_next;
  logic valid_reg, valid_next;
  logic [TAG_W-1:0] take_tag;

  always_comb begin
    take_tag = (arm_evt) ? arm_tag : ptag_reg;
    word_next = word_reg;
    below_next = below_reg;
    full_next = full_reg;
    tag_next = tag_reg;
    valid_next = take;
    if (take) begin
      word_next = pins_lvl[5:0];
      // Flag is active low on the pin; data reads pulled up then
      below_next = ~pins_lvl[6];
      // Below range also shows all ones, so flag the full code only with the flag pin high
      full_next = pins_lvl[6] && (pins_lvl[5:0] == `FSC_DATA_FULL);
      tag_next = take_tag;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      word_reg <= '0;
      below_reg <= 1'b0;
      full_reg <= 1'b0;
      tag_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      below_reg <= below_next;
      full_reg <= full_next;
      tag_reg <= tag_next;
      valid_reg <= valid_next;
    end
  end

  // ==========================================================
  // Timing check of the chosen capture scheme, in nanoseconds (picoseconds for the lagged scheme's period)
  // Widened products keep large phase counts from wrapping.
  logic fault_reg, fault_next;
  logic [31:0] low_ns, per_ns, per_ps;
  logic dis_reg, dis_next;

  always_comb begin
    low_ns = 32'(low_len) * 32'(`FSC_CLK_PERIOD_NS);
    per_ns = (32'(high_len) + 32'(low_len)) * 32'(`FSC_CLK_PERIOD_NS);
    per_ps = per_ns * 32'h0000_03E8;
    case (CAPTURE_MODE)
      `FSC_MODE_RISE_NEXT: begin
        fault_next = (low_ns <= 32'(`FSC_T_VALID_NS));
      end
      `FSC_MODE_FALL_NEXT: begin
        fault_next = (per_ns < 32'(`FSC_T_FALL_PERIOD_NS));
      end
      `FSC_MODE_RISE_LAG: begin
        fault_next = (low_ns >= 32'(`FSC_T_HOLD_NS)) ||
                     (per_ps < 32'(`FSC_T_LAG_PERIOD_PS));
      end
      default: begin
        fault_next = 1'b0;
      end
    endcase
    // Disable pin high turns the converter's data drivers off
    dis_next = ~OUTPUT_ON;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      fault_reg <= 1'b0;
      dis_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      dis_reg <= dis_next;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flip-flop
  assign STROBE = strobe_reg;
  assign OUT_DISABLE = dis_reg;
  assign WORD = word_reg;
  assign BELOW_RANGE = below_reg;
  assign FULL_SCALE = full_reg;
  assign WORD_TAG = tag_reg;
  assign WORD_VALID = valid_reg;
  assign TIMING_FAULT = fault_reg;
  assign BUSY = pend_reg;

endmodule

/* verilog/fsc_cfg.svh */
/*
  Constants for the flash converter strobe and capture controller:
  timing figures in their own units and the cycle counts derived from them.
  Assumes a single system clock at the rate given by FSC_CLK_PERIOD_NS.
*/
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH

// ==========================================================
// Clock
`define FSC_CLK_PERIOD_NS 100

// ==========================================================
// Converter timing figures
`define FSC_T_HIGH_MIN_NS 20
`define FSC_T_LOW_MIN_NS 40
`define FSC_T_PERIOD_MIN_PS 62500
`define FSC_T_VALID_NS 120
`define FSC_T_HOLD_NS 50
`define FSC_T_APERTURE_NS 20
`define FSC_T_FALL_PERIOD_NS 120
`define FSC_T_LAG_PERIOD_PS 71429

// ==========================================================
// Derived cycle counts, least times rounded up, never below one
`define FSC_CEIL_CYC(t) (((t) + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`define FSC_AT_LEAST1(x) (((x) < 1) ? 1 : (x))
`define FSC_HIGH_MIN_CYC `FSC_AT_LEAST1(`FSC_CEIL_CYC(`FSC_T_HIGH_MIN_NS))
`define FSC_LOW_MIN_CYC `FSC_AT_LEAST1(`FSC_CEIL_CYC(`FSC_T_LOW_MIN_NS))
`define FSC_PERIOD_MIN_CYC `FSC_AT_LEAST1(`FSC_CEIL_CYC((`FSC_T_PERIOD_MIN_PS + 999) / 1000))

// ==========================================================
// Capture modes
`define FSC_MODE_RISE_NEXT 2'h0
`define FSC_MODE_FALL_NEXT 2'h1
`define FSC_MODE_RISE_LAG 2'h2
`define FSC_MODE_TRIMMED 2'h3

// ==========================================================
// Pin idle level and full-scale code (outputs are pulled up when not driven)
`define FSC_DATA_IDLE 6'h3F
`define FSC_DATA_FULL 6'h3F

`endif

/* verilog/fsc_pkg.sv */
/*
  Types shared by the strobe and capture controller.
  Assumes fsc_cfg.svh supplies the numeric constants.
*/
package fsc_pkg;

  // ==========================================================
  // Strobe generator states, Gray coded along idle-high-low
  typedef enum logic [1:0] {
    FSC_IDLE = 2'h0,
    FSC_HIGH = 2'h1,
    FSC_LOW = 2'h3
  } fsc_state_e;

  typedef logic [1:0] fsc_mode_t;

endpackage

/* verilog/fsc_pin_sync.sv */
/*
  Three-stage synchroniser for a group of pin inputs.
  A bit's filtered value changes only once stages two and three agree.
  Assumes one clock and a synchronous active-high reset.
*/
module fsc_pin_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [WIDTH-1:0] s1_next, s2_next, s3_next, lvl_next;

  // ==========================================================
  // Per-bit filter; stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        s1_next[gi] = pin_in[gi];
        s2_next[gi] = s1_reg[gi];
        s3_next[gi] = s2_reg[gi];
        lvl_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : lvl_reg[gi];
      end
    end
  endgenerate

  // Registers only
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
      lvl_reg <= IDLE;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;

endmodule

/* verif/fsc_capture_monitor.sv */
/* Checker for the strobe and capture controller ports.
   Assumes it is bound onto fsc_capture. */
module fsc_capture_monitor #(
  parameter int CNT_W = 8,
  parameter int TRIM_W = 4,
  parameter int TAG_W = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Controls
  input wire logic [CNT_W-1:0] HIGH_CYCLES,
  input wire logic [CNT_W-1:0] LOW_CYCLES,
  input wire logic [1:0] CAPTURE_MODE,
  input wire logic [TRIM_W-1:0] CAPTURE_TRIM,
  input wire logic OUTPUT_ON,
  // Pins and results
  input wire logic STROBE,
  input wire logic OUT_DISABLE,
  input wire logic [TAG_W-1:0] WORD_TAG,
  input wire logic WORD_VALID,
  input wire logic BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Phase and sample counters
  logic str_reg, str_next;
  logic [CNT_W-1:0] hi_reg, hi_next, lo_reg, lo_next;
  logic [TAG_W-1:0] fc_reg, fc_next;
  logic [CNT_W-1:0] pd_reg, pd_next;
  logic v0, v1, v2, v3;

  function automatic logic [CNT_W-1:0] cl(input logic [CNT_W-1:0] v);
    return (v == '0) ? CNT_W'(1) : v;
  endfunction

  // Saturate the high count, since the strobe idles high for long spans
  always_comb begin
    str_next = STROBE;
    hi_next = !STROBE ? '0 : (&hi_reg) ? hi_reg : hi_reg + CNT_W'(1);
    lo_next = STROBE ? '0 : lo_reg + CNT_W'(1);
    fc_next = fc_reg + TAG_W'(str_reg & ~STROBE);
    // Clocks between falls; saturates so the first fall after idle passes
    pd_next = (str_reg & ~STROBE) ? CNT_W'(1) : (&pd_reg) ? pd_reg : pd_reg + CNT_W'(1);
  end

  // Counter registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      str_reg <= 1'b1;
      hi_reg <= '0;
      lo_reg <= '0;
      fc_reg <= '0;
      pd_reg <= '1;
    end else begin
      str_reg <= str_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      fc_reg <= fc_next;
      pd_reg <= pd_next;
    end
  end

  // Capture qualifiers per mode with no trim; mode 3 with a trim of two, not gated by valid
  assign v0 = WORD_VALID && CAPTURE_MODE == 2'h0 && CAPTURE_TRIM == '0;
  assign v1 = WORD_VALID && CAPTURE_MODE == 2'h1 && CAPTURE_TRIM == '0;
  assign v2 = WORD_VALID && CAPTURE_MODE == 2'h2 && CAPTURE_TRIM == '0;
  assign v3 = CAPTURE_MODE == 2'h3 && CAPTURE_TRIM == TRIM_W'(2);

  // ==========
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  high_min_a: assert property ($fell(STROBE) |-> hi_reg >= cl(HIGH_CYCLES))
    else $error("strobe high phase too short");
  low_exact_a: assert property ($rose(STROBE) |-> lo_reg == cl(LOW_CYCLES))
    else $error("strobe low phase length wrong");
  valid_pulse_a: assert property (WORD_VALID |=> !WORD_VALID)
    else $error("valid longer than one cycle");
  rise_next_a: assert property (v0 |-> $rose(STROBE) && WORD_TAG == fc_reg - TAG_W'(1))
    else $error("rise capture edge or tag wrong");
  fall_next_a: assert property (v1 |-> $fell(STROBE) && WORD_TAG == fc_reg - TAG_W'(1))
    else $error("fall capture edge or tag wrong");
  rise_lag_a: assert property (v2 |-> $rose(STROBE) && WORD_TAG == fc_reg - TAG_W'(2))
    else $error("lagged capture edge or tag wrong");
  trim_wait_a: assert property ($fell(STROBE) && v3 |-> !WORD_VALID ##1 BUSY ##1 WORD_VALID)
    else $error("trimmed capture delay wrong");
  disable_pin_a: assert property (1'b1 |=> OUT_DISABLE == !$past(OUTPUT_ON))
    else $error("output disable pin wrong");
  rate_max_a: assert property ($fell(STROBE) |-> pd_reg >= CNT_W'(2))
    else $error("strobe period too short");

  cover property (v0);
  cover property (v2);
  cover property (WORD_VALID && v3);
endmodule

/* verif/fsc_adc_model.sv */
/* Behavioural flash converter at the far side of the controller.
   Assumes level codes: 00-3F in range, 40 above, FF below. */
module fsc_adc_model #(
  parameter int VALID_NS = 120,
  parameter int HOLD_NS = 50
) (
  // Strobe, output disable and input level
  input wire logic strobe,
  input wire logic out_disable,
  input wire logic [7:0] level,
  // Open-collector outputs, pulled up
  output logic [5:0] data_pin,
  output logic under_n_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] d = 6'h3F;
  logic u = 1'b1;
  logic off = 1'b1;
  logic [7:0] s;
  int code;

  // Track while high; freeze after the aperture delay, then slow outputs
  always @(negedge strobe) begin
    #20 s = level;
    code = 0;
    for (int i = 0; i < 63; i++) begin
      if (s > i && s != 8'hFF) code = i + 1;
    end
    #(HOLD_NS - 20) d = ~d;
    u = ~u;
    off = 1'b0;
    #(VALID_NS - HOLD_NS) d = 6'(code);
    u = s != 8'hFF;
    off = s > 8'h3F;
  end

  // Released drivers read as the pull-up level
  assign data_pin = (out_disable || off) ? 6'h3F : d;
  assign under_n_pin = u;
endmodule

/* verif/fsc_capture_tb.sv */
/* Self-checking bench for fsc_capture with a converter model.
   Assumes fsc_cfg.svh is on the include path. */
module fsc_capture_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, run = 1'b0, output_on = 1'b1, strobe_d = 1'b1;
  logic [7:0] high_cycles = 8'h02, low_cycles = 8'h07, level = 8'h00;
  logic [1:0] capture_mode = 2'h0;
  logic [3:0] capture_trim = 4'h0;
  logic strobe, out_disable, under_n, below_range, full_scale;
  logic word_valid, timing_fault, busy;
  logic [5:0] data_pin, word;
  logic [7:0] word_tag;
  int fail_count = 0, num_checks = 0, falls = 0;

  fsc_capture fsc_capture_inst (.CLK(clk), .RESET(reset), .RUN(run),
    .HIGH_CYCLES(high_cycles), .LOW_CYCLES(low_cycles), .CAPTURE_MODE(capture_mode),
    .CAPTURE_TRIM(capture_trim), .OUTPUT_ON(output_on), .STROBE(strobe),
    .OUT_DISABLE(out_disable), .DATA_PIN(data_pin), .UNDER_N_PIN(under_n), .WORD(word),
    .BELOW_RANGE(below_range), .FULL_SCALE(full_scale), .WORD_TAG(word_tag),
    .WORD_VALID(word_valid), .TIMING_FAULT(timing_fault), .BUSY(busy));
  fsc_adc_model fsc_adc_model_inst (.strobe(strobe), .out_disable(out_disable),
    .level(level), .data_pin(data_pin), .under_n_pin(under_n));

  always #50 clk = ~clk;

  // Input level per sample number, with one below-range and one above-range sample in every eight
  function automatic logic [7:0] lvl(input int t);
    case (t % 8)
      5: return 8'hFF;
      6: return 8'h40;
      default: return 8'((t * 23 + 9) % 64);
    endcase
  endfunction

  // New level after each fall, so it stands through the next high phase
  always @(negedge clk) begin
    if (reset) falls = 0;
    else if (strobe_d && !strobe) falls++;
    strobe_d = strobe;
    level = lvl(falls);
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Reset with new settings; four cycles flush the pin filter
  task automatic start(input logic [1:0] m, input logic [7:0] h, l, input logic [3:0] tr,
    input logic on);
    reset = 1'b1;
    capture_mode = m;
    high_cycles = h;
    low_cycles = l;
    capture_trim = tr;
    output_on = on;
    repeat (4) @(negedge clk);
    reset = 1'b0;
  endtask

  // Run six captures and judge all but the first two, which precede valid data
  task automatic collect(input logic flt);
    int k, w;
    logic [7:0] v;
    run = 1'b1;
    k = 0;
    w = 0;
    while (k < 6 && w < 400) begin
      @(negedge clk);
      w++;
      if (word_valid === 1'b1) begin
        k++;
        v = lvl(int'(word_tag));
        if (k > 2) begin
          chk("word", {2'h0, word}, (v > 8'h3F || !output_on) ? 8'h3F : v);
          chk("below", 8'(below_range), 8'(v == 8'hFF));
          chk("full", 8'(full_scale), 8'(v != 8'hFF && (v > 8'h3E || !output_on)));
          chk("fault", 8'(timing_fault), 8'(flt));
        end
      end
    end
    chk("count", 8'(k), 8'h06);
    run = 1'b0;
    repeat (20) @(negedge clk);
  endtask

  task automatic rise_next();
    start(2'h0, 8'h00, 8'h07, 4'h0, 1'b1);
    collect(1'b0);
  endtask

  task automatic fall_next();
    start(2'h1, 8'h03, 8'h04, 4'h0, 1'b1);
    collect(1'b0);
  endtask

  // One-cycle low phase outlasts the 50 ns hold, so the timing fault is expected; zero low clamps to one
  task automatic rise_lag();
    start(2'h2, 8'h04, 8'h00, 4'h0, 1'b1);
    collect(1'b1);
  endtask

  task automatic trimmed();
    start(2'h3, 8'h03, 8'h03, 4'h2, 1'b1);
    collect(1'b0);
  endtask

  task automatic outputs_off();
    start(2'h0, 8'h02, 8'h07, 4'h0, 1'b0);
    collect(1'b0);
  endtask

  initial begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    rise_next();
    fall_next();
    rise_lag();
    trimmed();
    outputs_off();
    test_done();
  end

  // Watchdog well beyond the five scenarios
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule

bind fsc_capture fsc_capture_monitor #(.CNT_W(CNT_W), .TRIM_W(TRIM_W), .TAG_W(TAG_W))
  fsc_capture_monitor_inst (.CLK(CLK), .RESET(RESET), .HIGH_CYCLES(HIGH_CYCLES),
  .LOW_CYCLES(LOW_CYCLES), .CAPTURE_MODE(CAPTURE_MODE), .CAPTURE_TRIM(CAPTURE_TRIM),
  .OUTPUT_ON(OUTPUT_ON), .STROBE(STROBE), .OUT_DISABLE(OUT_DISABLE),
  .WORD_TAG(WORD_TAG), .WORD_VALID(WORD_VALID), .BUSY(BUSY));
